// ==== hw/ptprc_params.svh ====
// constants of the time-clock rate and access-checksum register block
// assumes a single 100 mhz clock and a word-wide register access port
//
// Summary of operation
// - time advances period plus/minus rate each cycle
// - low-half write loads whole rate atomically
// - high holds bits 25:16, low 15:0
// - high bit 15: 0 adds, 1 subtracts
// - high bit 14: rate only while temporary
// - high bits 13:10 ignore writes, read zero
// - read sum folds every page read
// - reading read sum clears it, not folded
// - write-sum read data folds into read sum
// - write sum folds every page write
// - writes to checksum registers still fold
// - reading write sum returns it, then clears
// - frame accesses never fold, but reads clear
`ifndef PTPRC_PARAMS_SVH
`define PTPRC_PARAMS_SVH

// -------------------------------------------------------------------
// register offsets within the timing page
// -------------------------------------------------------------------
`define PTPRC_OFS_RATE_LOW   5'h18
`define PTPRC_OFS_RATE_HIGH  5'h19
`define PTPRC_OFS_RD_SUM     5'h1a
`define PTPRC_OFS_WR_SUM     5'h1b

// -------------------------------------------------------------------
// field positions of the high-half rate register
// -------------------------------------------------------------------
`define PTPRC_HI_DIR_BIT     15
`define PTPRC_HI_TMP_BIT     14
`define PTPRC_HI_MAG_MSB     9
`define PTPRC_RATE_W         26
`define PTPRC_HI_MAG_W       10

// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define PTPRC_RST_RATE_LOW   16'h0000
`define PTPRC_RST_RATE_HIGH  16'h0000
`define PTPRC_RST_SUM        16'h0000

// -------------------------------------------------------------------
// timing: reference period from the clock rate
// -------------------------------------------------------------------
`define PTPRC_CLK_MHZ        100
`define PTPRC_REF_PERIOD_NS  (1000 / `PTPRC_CLK_MHZ)

`endif

// ==== hw/ptprc_pkg.sv ====
// types shared by the rate and checksum block
// assumes the params header sits beside it
`include "ptprc_params.svh"

package ptprc_pkg;

    typedef logic [15:0]              ptprc_word_t;   // register word
    typedef logic [4:0]               ptprc_addr_t;   // page offset
    typedef logic [`PTPRC_RATE_W-1:0] ptprc_rate_t;   // rate magnitude

    // one's complement add with end-around carry
    function automatic ptprc_word_t ptprc_oc_add(input ptprc_word_t a,
                                                 input ptprc_word_t b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

endpackage

// ==== hw/ptprc_rate_if.sv ====
// carrier of the active rate from the register bank to the clock adder
// assumes both ends share sys_clk
interface ptprc_rate_if;
    import ptprc_pkg::*;

    ptprc_rate_t mag;   // active rate magnitude
    logic        dir;   // 1 subtracts
    logic        tmp;   // temporary rate in force

    modport src  (output mag, output dir, output tmp);
    modport sink (input  mag, input  dir, input  tmp);
endinterface

// ==== hw/ptprc_clock_adder.sv ====
// time clock accumulator: ns plus 32 fractional bits
// assumes the active rate changes only on whole-cycle boundaries
module ptprc_clock_adder
    import ptprc_pkg::*;
#(
    parameter int NS_W = 32
)(
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            srst,
    // active rate
    ptprc_rate_if.sink           rate,
    input  wire logic            tmp_window_open,
    // time out
    output logic [NS_W-1:0]      time_ns,
    output logic [31:0]          time_frac
);

    // -------------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------------
    generate
        if (NS_W < 8)
        begin : g_bad_width
            $error("ptprc_clock_adder: NS_W too small");
        end
    endgenerate

    localparam int TW = NS_W + 32;

    logic [TW-1:0] time_r;     // ns and fraction
    logic [TW-1:0] time_nxt;
    logic [TW-1:0] step;       // nominal period in 2^-32 ns
    logic [TW-1:0] adj;        // rate widened
    logic          apply;      // rate applied this cycle

    // -------------------------------------------------------------------
    // next time value
    // -------------------------------------------------------------------
    always_comb
    begin
        step  = {NS_W'(`PTPRC_REF_PERIOD_NS), 32'h0000_0000};
        adj   = TW'(rate.mag);
        // temporary rate only counts while its window is open
        apply = !rate.tmp || tmp_window_open;
        if (!apply)
        begin
            time_nxt = time_r + step;
        end
        else if (rate.dir)
        begin
            time_nxt = time_r + step - adj;
        end
        else
        begin
            time_nxt = time_r + step + adj;
        end
    end

    // time register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            time_r <= '0;
        else
            time_r <= time_nxt;
    end

    assign time_ns   = time_r[TW-1:32];
    assign time_frac = time_r[31:0];

endmodule // ptprc_clock_adder

// ==== hw/ptprc_regs.sv ====
// rate registers, access checksums and the time clock they steer
// assumes the management decoder presents one access per cycle,
// on sys_clk, with the page already resolved
`include "ptprc_params.svh"

module ptprc_regs
    import ptprc_pkg::*;
#(
    parameter int NS_W = 32
)(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          srst,
    // register access port
    input  wire logic          acc_valid,   // one-cycle access strobe
    input  wire logic          acc_write,   // 1 write, 0 read
    input  wire logic          acc_page,    // access targets timing page
    input  wire logic          acc_frame,   // access from a control frame
    input  wire ptprc_addr_t   acc_addr,
    input  wire ptprc_word_t   acc_wdata,
    input  wire ptprc_word_t   ext_rdata,   // other page registers
    output ptprc_word_t        rd_data,
    output logic               rd_valid,
    // temporary-rate duration logic
    input  wire logic          tmp_window_open,
    output logic               tmp_rate_start,
    output logic               rate_tmp_active,
    // time clock
    output logic [NS_W-1:0]    time_ns,
    output logic [31:0]        time_frac
);

    // -------------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------------
    generate
        if (NS_W < 8)
        begin : g_bad_width
            $error("ptprc_regs: NS_W too small");
        end
    endgenerate

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    ptprc_word_t  low_r,  low_nxt;     // rate low word, readable
    logic [`PTPRC_HI_MAG_W-1:0] hi_r, hi_nxt;   // staged high bits
    logic         dir_r,  dir_nxt;     // staged direction
    logic         tmp_r,  tmp_nxt;     // staged temporary flag
    ptprc_rate_t  amag_r, amag_nxt;    // active magnitude
    logic         adir_r, adir_nxt;    // active direction
    logic         atmp_r, atmp_nxt;    // active temporary flag
    logic         start_r, start_nxt;  // pulse on temporary load
    ptprc_word_t  rsum_r, rsum_nxt;    // read checksum
    ptprc_word_t  wsum_r, wsum_nxt;    // write checksum
    ptprc_word_t  rdat_r, rdat_nxt;    // registered read data
    logic         rval_r, rval_nxt;    // read answer strobe

    logic         pg_rd;               // page read this cycle
    logic         pg_wr;               // page write this cycle
    ptprc_word_t  rsel;                // data the read returns
    ptprc_word_t  hi_view;             // high register as read

    // -------------------------------------------------------------------
    // read data selection
    // -------------------------------------------------------------------
    always_comb
    begin
        hi_view = '0;
        hi_view[`PTPRC_HI_DIR_BIT] = dir_r;
        hi_view[`PTPRC_HI_TMP_BIT] = tmp_r;
        hi_view[`PTPRC_HI_MAG_MSB:0] = hi_r;
        pg_rd = acc_valid && acc_page && !acc_write;
        pg_wr = acc_valid && acc_page && acc_write;
        case (acc_addr)
            `PTPRC_OFS_RATE_LOW:  rsel = low_r;
            `PTPRC_OFS_RATE_HIGH: rsel = hi_view;
            `PTPRC_OFS_RD_SUM:    rsel = rsum_r;
            `PTPRC_OFS_WR_SUM:    rsel = wsum_r;
            default:              rsel = ext_rdata;   // rest of page
        endcase
    end

    // -------------------------------------------------------------------
    // rate registers: next values
    // -------------------------------------------------------------------
    // the high half only stages; nothing moves into the active rate
    // until the low half lands, so a half-written rate is never used
    always_comb
    begin
        low_nxt   = low_r;
        hi_nxt    = hi_r;
        dir_nxt   = dir_r;
        tmp_nxt   = tmp_r;
        amag_nxt  = amag_r;
        adir_nxt  = adir_r;
        atmp_nxt  = atmp_r;
        start_nxt = 1'b0;
        if (pg_wr && acc_addr == `PTPRC_OFS_RATE_HIGH)
        begin
            // bits 13:10 are dropped here
            dir_nxt = acc_wdata[`PTPRC_HI_DIR_BIT];
            tmp_nxt = acc_wdata[`PTPRC_HI_TMP_BIT];
            hi_nxt  = acc_wdata[`PTPRC_HI_MAG_MSB:0];
        end
        else if (pg_wr && acc_addr == `PTPRC_OFS_RATE_LOW)
        begin
            // host is expected to have written the high half first
            low_nxt   = acc_wdata;
            amag_nxt  = {hi_r, acc_wdata};
            adir_nxt  = dir_r;
            atmp_nxt  = tmp_r;
            start_nxt = tmp_r;
        end
    end

    // rate registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            low_r   <= `PTPRC_RST_RATE_LOW;
            // only the magnitude bits of the reset word are kept here
            hi_r    <= `PTPRC_HI_MAG_W'(`PTPRC_RST_RATE_HIGH);
            dir_r   <= 1'b0;
            tmp_r   <= 1'b0;
            amag_r  <= '0;
            adir_r  <= 1'b0;
            atmp_r  <= 1'b0;
            start_r <= 1'b0;
        end
        else
        begin
            low_r   <= low_nxt;
            hi_r    <= hi_nxt;
            dir_r   <= dir_nxt;
            tmp_r   <= tmp_nxt;
            amag_r  <= amag_nxt;
            adir_r  <= adir_nxt;
            atmp_r  <= atmp_nxt;
            start_r <= start_nxt;
        end
    end

    // -------------------------------------------------------------------
    // checksums and read answer: next values
    // -------------------------------------------------------------------
    // frame accesses never fold but still clear on read; the clear of
    // one sum and the fold into the other happen in the same cycle
    always_comb
    begin
        rsum_nxt = rsum_r;
        wsum_nxt = wsum_r;
        rdat_nxt = rdat_r;
        rval_nxt = 1'b0;
        if (pg_rd)
        begin
            rdat_nxt = rsel;
            rval_nxt = 1'b1;
            if (acc_addr == `PTPRC_OFS_RD_SUM)
            begin
                rsum_nxt = `PTPRC_RST_SUM;
            end
            else if (!acc_frame)
            begin
                // includes the write-sum value being read out
                rsum_nxt = ptprc_oc_add(rsum_r, rsel);
            end
            if (acc_addr == `PTPRC_OFS_WR_SUM)
            begin
                wsum_nxt = `PTPRC_RST_SUM;
            end
        end
        else if (pg_wr && !acc_frame)
        begin
            // writes to either sum register still fold
            wsum_nxt = ptprc_oc_add(wsum_r, acc_wdata);
        end
    end

    // checksum registers; reset value is ours, software clears anyway
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rsum_r <= `PTPRC_RST_SUM;
            wsum_r <= `PTPRC_RST_SUM;
            rdat_r <= '0;
            rval_r <= 1'b0;
        end
        else
        begin
            rsum_r <= rsum_nxt;
            wsum_r <= wsum_nxt;
            rdat_r <= rdat_nxt;
            rval_r <= rval_nxt;
        end
    end

    // -------------------------------------------------------------------
    // time clock
    // -------------------------------------------------------------------
    ptprc_rate_if rate_link ();

    assign rate_link.mag = amag_r;
    assign rate_link.dir = adir_r;
    assign rate_link.tmp = atmp_r;

    ptprc_clock_adder #(
        .NS_W            (NS_W)
    ) u_adder (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .rate            (rate_link.sink),
        .tmp_window_open (tmp_window_open),
        .time_ns         (time_ns),
        .time_frac       (time_frac)
    );

    // -------------------------------------------------------------------
    // outputs, all straight from flops
    // -------------------------------------------------------------------
    assign rd_data         = rdat_r;
    assign rd_valid        = rval_r;
    assign tmp_rate_start  = start_r;
    assign rate_tmp_active = atmp_r;

endmodule // ptprc_regs

// ==== bench/ptprc_host_model.sv ====
// host model: management side of the register access port
// assumes the caller acts at sys_clk falling edges
module ptprc_host_model
    import ptprc_pkg::*;
(
    // clock
    input  wire logic   sys_clk,
    // access strobe and qualifiers
    output logic        acc_valid,
    output logic        acc_write,
    output logic        acc_page,
    output logic        acc_frame,
    output ptprc_addr_t acc_addr,
    output ptprc_word_t acc_wdata,
    // other page registers' read data
    output ptprc_word_t ext_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // quiet port at time zero
    initial
    begin
        {acc_valid, acc_write, acc_page, acc_frame} = 4'h0;
        acc_addr  = 5'h00;
        acc_wdata = 16'h0000;
        ext_rdata = 16'h0000;
    end

    // one access over one rising edge; valid stays up so that
    // calls chain back to back with no gap
    task automatic acc(input logic w, pg, fr, input ptprc_addr_t a,
                       input ptprc_word_t d);
        acc_valid <= 1'h1;
        acc_write <= w;
        acc_page  <= pg;
        acc_frame <= fr;
        acc_addr  <= a;
        acc_wdata <= w ? d : ~d; // junk data on reads
        ext_rdata <= d;
        @(negedge sys_clk);
    endtask

    // release: data lines flip so a stale value never passes
    task automatic idle();
        acc_valid <= 1'h0;
        acc_wdata <= ~acc_wdata;
        ext_rdata <= ~ext_rdata;
        @(negedge sys_clk);
    endtask
endmodule // ptprc_host_model

// ==== bench/ptprc_regs_assertions.sv ====
// checker for the rate and checksum register bank
// assumes it is bound to ptprc_regs and sees only its ports
`include "ptprc_params.svh"

module ptprc_regs_assertions
    import ptprc_pkg::*;
#(
    parameter int NS_W = 32
)(
    // clock and reset
    input wire logic            sys_clk,
    input wire logic            srst,
    // access port
    input wire logic            acc_valid,
    input wire logic            acc_write,
    input wire logic            acc_page,
    input wire ptprc_addr_t     acc_addr,
    input wire ptprc_word_t     acc_wdata,
    input wire ptprc_word_t     rd_data,
    input wire logic            rd_valid,
    // rate load and time
    input wire logic            tmp_rate_start,
    input wire logic [NS_W-1:0] time_ns
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // taken page accesses, by kind
    wire rd_q  = acc_valid && acc_page && !acc_write;
    wire wr_q  = acc_valid && acc_page && acc_write;
    wire rd_rs = rd_q && acc_addr == `PTPRC_OFS_RD_SUM;
    wire rd_ws = rd_q && acc_addr == `PTPRC_OFS_WR_SUM;
    wire rd_hi = rd_q && acc_addr == `PTPRC_OFS_RATE_HIGH;
    wire wr_hi = wr_q && acc_addr == `PTPRC_OFS_RATE_HIGH;
    wire wr_lo = wr_q && acc_addr == `PTPRC_OFS_RATE_LOW;

    // ------------------------------
    // access answers and checksums
    // ------------------------------
    property p_rd_answer; rd_q |=> rd_valid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("page read not answered next cycle");
    // past reset guard: a one-cycle reset may move rd_data
    property p_rd_hold; !rd_valid && !$past(srst) |-> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_rd_sum_clear; rd_rs ##1 rd_rs |=> rd_data == 16'h0000;
    endproperty
    a_rd_sum_clear: assert property (p_rd_sum_clear)
        else $error("read sum not cleared by its read");
    property p_wr_sum_clear; rd_ws ##1 rd_ws |=> rd_data == 16'h0000;
    endproperty
    a_wr_sum_clear: assert property (p_wr_sum_clear)
        else $error("write sum not cleared by its read");
    property p_high_rsvd; rd_hi |=> rd_data[13:10] == 4'h0; endproperty
    a_high_rsvd: assert property (p_high_rsvd)
        else $error("reserved rate bits not zero");

    // ------------------------------
    // rate loading and time advance
    // ------------------------------
    property p_tmp_load;
        wr_hi && acc_wdata[`PTPRC_HI_TMP_BIT] ##1 wr_lo |=> tmp_rate_start;
    endproperty
    a_tmp_load: assert property (p_tmp_load)
        else $error("temporary rate not started by low write");
    property p_high_alone; !wr_lo |=> !tmp_rate_start; endproperty
    a_high_alone: assert property (p_high_alone)
        else $error("rate loaded without a low write");
    // rate is below one ns, so whole ns step is 9, 10 or 11
    property p_time_step;
        1'h1 |=> (time_ns - $past(time_ns)) inside {9, 10, 11};
    endproperty
    a_time_step: assert property (p_time_step)
        else $error("time clock step out of range");

    // main scenarios reached
    c_rs_clear: cover property (rd_rs ##1 rd_rs);
    c_rate_load: cover property (wr_hi ##1 wr_lo);
    c_tmp_start: cover property (tmp_rate_start);
endmodule // ptprc_regs_assertions

// ==== bench/ptprc_regs_tb.sv ====
// self-checking bench: rate registers, checksums, time clock
// assumes design, host model and checker compile before it
`include "ptprc_params.svh"

module ptprc_regs_tb
    import ptprc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk, srst, tmp_window_open;
    logic        acc_valid, acc_write, acc_page, acc_frame;
    logic        rd_valid, tmp_rate_start, rate_tmp_active;
    ptprc_addr_t acc_addr;
    ptprc_word_t acc_wdata, ext_rdata, rd_data;
    logic [31:0] time_ns, time_frac;
    ptprc_word_t m_lo, m_hi, m_rs, m_ws; // expected bank state
    int          err_total, n_tests;
    int          cyc = 0;

    // table row: write, page, frame, offset, data, read data after it
    typedef struct packed {
        logic        w, pg, fr;
        ptprc_addr_t a;
        ptprc_word_t d;
        ptprc_word_t e;   // rd_data expected once the row is taken
    } ptprc_row_t;
    // clear sums; rate words; writes to sums; cross-check reads;
    // frame accesses; off-page accesses; final sum
    localparam ptprc_row_t ROWS [20] = '{
        40'h5a0000_0000, 40'h5b0000_0000, 40'hd9ffff_0000, 40'h590000_c3ff,
        40'hd81234_c3ff, 40'h580000_1234, 40'hda8001_1234, 40'hdbffff_1234,
        40'h43abcd_abcd, 40'h5b0000_9235, 40'h5b0000_0000, 40'h5a0000_1437,
        40'h5a0000_0000, 40'he55555_0000, 40'h677777_7777, 40'h7b0000_0000,
        40'h990000_0000, 40'h030000_0000, 40'h590000_c3ff, 40'h5a0000_c3ff};

    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    ptprc_host_model u_host (
        .sys_clk(sys_clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_page(acc_page), .acc_frame(acc_frame), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .ext_rdata(ext_rdata));

    ptprc_regs #(.NS_W(32)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_page(acc_page),
        .acc_frame(acc_frame), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .ext_rdata(ext_rdata),
        .rd_data(rd_data), .rd_valid(rd_valid),
        .tmp_window_open(tmp_window_open),
        .tmp_rate_start(tmp_rate_start),
        .rate_tmp_active(rate_tmp_active),
        .time_ns(time_ns), .time_frac(time_frac));

    task automatic conclude();
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // own one's complement add, end-around carry
    function automatic ptprc_word_t oc(input ptprc_word_t a, b);
        logic [16:0] s;
        s = {1'h0, a} + {1'h0, b};
        return s[15:0] + 16'(s[16]);
    endfunction

    // one access, then the model follows it
    task automatic op(input ptprc_row_t r);
        ptprc_word_t v;
        u_host.acc(r.w, r.pg, r.fr, r.a, r.d);
        v = r.d;
        if (r.pg && r.w)
        begin
            if (!r.fr)
                m_ws = oc(m_ws, r.d);
            if (r.a == `PTPRC_OFS_RATE_LOW)
                m_lo = r.d;
            if (r.a == `PTPRC_OFS_RATE_HIGH)
                m_hi = r.d & 16'hc3ff;
        end
        else if (r.pg)
        begin
            case (r.a)
                `PTPRC_OFS_RATE_LOW:  v = m_lo;
                `PTPRC_OFS_RATE_HIGH: v = m_hi;
                `PTPRC_OFS_RD_SUM:    v = m_rs;
                `PTPRC_OFS_WR_SUM:    v = m_ws;
                default:              v = r.d;
            endcase
            chk(rd_data, v);
            if (r.a == `PTPRC_OFS_RD_SUM)
                m_rs = 16'h0000;
            else if (!r.fr)
                m_rs = oc(m_rs, v);
            if (r.a == `PTPRC_OFS_WR_SUM)
                m_ws = 16'h0000;
        end
        chk(rd_valid, r.pg && !r.w);
    endtask

    // whole time advance over one cycle; a subtracted rate borrows
    // one ns from the nominal period
    task automatic meas(input logic [31:0] exp);
        logic [63:0] t0;
        logic [63:0] dt;
        t0 = {time_ns, time_frac};
        @(negedge sys_clk);
        dt = {time_ns, time_frac} - t0;
        chk(dt[31:0], exp);
        chk(dt[63:32], 32'(`PTPRC_REF_PERIOD_NS) - 32'(exp[31]));
    endtask

    // high half first, then the loading low half
    task automatic rate(input ptprc_word_t hi, lo, input logic [31:0] exp);
        op({3'h6, `PTPRC_OFS_RATE_HIGH, hi, 16'h0000});
        op({3'h6, `PTPRC_OFS_RATE_LOW, lo, 16'h0000});
        chk(tmp_rate_start, hi[14]);
        chk(rate_tmp_active, hi[14]);
        u_host.idle();
        meas(exp);
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            $display("MISMATCH t=%0t timeout", $time);
            conclude();
        end
    end

    initial
    begin
        srst = 1'h1;
        tmp_window_open = 1'h0;
        {m_lo, m_hi, m_rs, m_ws} = 64'h0;
        err_total = 0;
        n_tests = 0;
        repeat (12) @(negedge sys_clk);
        srst = 1'h0;
        foreach (ROWS[i])
        begin
            op(ROWS[i]);
            chk(rd_data, ROWS[i].e);
        end
        u_host.idle();
        rate(16'h0000, 16'h8000, 32'h0000_8000);
        rate(16'h8000, 16'h8000, 32'hffff_8000);
        rate(16'h0001, 16'h0000, 32'h0001_0000);
        rate(16'h03ff, 16'hffff, 32'h03ff_ffff);
        op({3'h6, `PTPRC_OFS_RATE_HIGH, 16'h8005, 16'h0000});
        u_host.idle();
        meas(32'h03ff_ffff);
        tmp_window_open = 1'h1;
        rate(16'h4000, 16'h0100, 32'h0000_0100);
        tmp_window_open = 1'h0;
        meas(32'h0000_0000);
        // reset in mid-run zeroes the bank
        srst = 1'h1;
        repeat (2) @(negedge sys_clk);
        srst = 1'h0;
        {m_lo, m_hi, m_rs, m_ws} = 64'h0;
        // read data and the temporary flag were nonzero before reset
        chk(rd_data, 16'h0000);
        chk(rate_tmp_active, 1'h0);
        chk(tmp_rate_start, 1'h0);
        op(40'h590000_0000);
        op(40'h5a0000_0000);
        u_host.idle();
        meas(32'h0000_0000);
        conclude();
    end
endmodule // ptprc_regs_tb

bind ptprc_regs ptprc_regs_assertions #(.NS_W(NS_W)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_page(acc_page), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .tmp_rate_start(tmp_rate_start), .time_ns(time_ns));
